// ==== verilog/sllc_top.sv ====
// Link lock control: frame serialiser with pattern requests, and a
// deserialiser that hunts, locks, supervises lock and gates its outputs.
// Assumes the serial input comes from a peer on an unrelated clock, and
// that receiver_timebase runs freely at the serial bit rate.
`timescale 1ns/100ps
`include "sllc_regs.svh"

// How it works
// [RULE1] Each 10-bit word leaves as one 12-bit serial frame with two clock bits, one bit a clock.
// [RULE2] The active-low lock output stays high while unlocked, low once locked, high on loss.
// [RULE3] The system keeps the receiver timebase running, possibly before this block wakes.
// [RULE4] Parallel outputs stay undriven until an incoming stream is seen and locked to.
// [RULE5] Either pattern request input being high makes the serialiser send patterns.
// [RULE6] The system should loop the lock output back to one pattern request input.
// [RULE7] The deserialiser can lock to plain random data by sliding its frame alignment.
// [RULE8] While lock is low, each recovered word is presented on the 10-bit output.
// [RULE9] Lock is dropped only after four invalid clock-bit frames in a row.
// [RULE10] Up to three words before a loss may be corrupt and are still output.
// [RULE11] After loss the hunt restarts and relocks on patterns or on random data.
// [RULE12] A request sends at least 1024 pattern frames, and more while it stays high.
// [RULE13] A low output gate input puts the data and recovered clock outputs off the bus.
// [RULE14] Every frame carries a one before the data and a zero after it.
module sllc_top
    import sllc_pkg::*;
#(
    parameter int DATA_W      = `SLLC_DATA_W,
    parameter int FIFO_DEPTH  = `SLLC_FIFO_DEPTH,
    parameter int SYNC_MIN    = `SLLC_SYNC_MIN,
    parameter int LOSS_FRAMES = `SLLC_LOSS_FRAMES,
    parameter int LOCK_FRAMES = `SLLC_LOCK_FRAMES
) (
    input  wire logic              clk,               // system clock, 100 MHz
    input  wire logic              rst_n,             // async reset, active low
    input  wire logic              receiver_timebase, // link clock, serial bit rate
    input  wire logic              tx_valid,          // host offers a word
    input  wire logic [DATA_W-1:0] tx_data,           // word to send
    output logic                   tx_ready,          // FIFO has room
    input  wire logic              pattern_request_a, // pattern request pin
    input  wire logic              pattern_request_b, // second pattern request pin
    output logic                   tx_serial,         // serial frame output
    input  wire logic              rx_serial,         // serial frame input
    input  wire logic              rx_out_enable,     // output gate pin, low disables
    output logic [DATA_W-1:0]      rx_word_o,         // recovered word
    output logic                   rx_word_oe,        // drive enable of rx_word_o
    output logic                   rx_clk_o,          // recovered word strobe
    output logic                   rx_clk_oe,         // drive enable of rx_clk_o
    output logic                   link_lock_n        // lock indicator, active low
);

    localparam logic [`SLLC_PHASE_W-1:0]    LAST_BIT  = `SLLC_PHASE_W'(`SLLC_FRAME_BITS - 1);
    localparam logic [`SLLC_SYNC_CNT_W-1:0] SYNC_LOAD = `SLLC_SYNC_CNT_W'(SYNC_MIN - 1);
    localparam logic [`SLLC_BAD_CNT_W-1:0]  BAD_LAST  = `SLLC_BAD_CNT_W'(LOSS_FRAMES - 1);
    localparam logic [`SLLC_GOOD_CNT_W-1:0] GOOD_LAST = `SLLC_GOOD_CNT_W'(LOCK_FRAMES - 1);

    sllc_host_t host_ff;
    sllc_host_t nxt_host;
    sllc_link_t link_ff;
    sllc_link_t nxt_link;

    logic              fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic              fifo_out_ready;
    logic              fifo_in_ready;

    // Words wait here until the serialiser reaches a frame boundary
    sllc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (tx_valid),
        .in_data   (tx_data),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (fifo_out_ready)
    );

    assign tx_ready    = fifo_in_ready;
    assign tx_serial   = host_ff.tx_shreg[`SLLC_FRAME_BITS-1];
    assign rx_word_o   = host_ff.rx_word;
    assign rx_word_oe  = host_ff.rx_word_oe;
    assign rx_clk_o    = host_ff.rx_clk;
    assign rx_clk_oe   = host_ff.rx_clk_oe;
    assign link_lock_n = host_ff.lock_n;

    // ------------------------------------------------------------------
    // System clock domain: serialiser and parallel output stage
    // ------------------------------------------------------------------
    logic              frame_end;
    logic              req_any;
    logic              send_sync;
    logic [DATA_W-1:0] frame_word;
    logic              word_arrived;

    always_comb begin
        nxt_host       = host_ff;
        fifo_out_ready = 1'b0;
        frame_word     = `SLLC_IDLE_WORD;
        send_sync      = 1'b0;

        // Pins pass two flops before use
        nxt_host.preq_meta = {pattern_request_b, pattern_request_a};
        nxt_host.preq_sync = host_ff.preq_meta;
        nxt_host.oe_meta   = rx_out_enable;
        nxt_host.oe_sync   = host_ff.oe_meta;

        // [RULE5] requests are ORed
        req_any   = |host_ff.preq_sync;
        frame_end = host_ff.tx_bit_idx == LAST_BIT;

        // [RULE1] one serial bit per clock
        nxt_host.tx_shreg   = {host_ff.tx_shreg[`SLLC_FRAME_BITS-2:0], 1'b0};
        nxt_host.tx_bit_idx = frame_end ? '0 : host_ff.tx_bit_idx + 1'b1;

        if (frame_end) begin
            // [RULE12] minimum pattern run, extended while held
            if (req_any) begin
                send_sync          = 1'b1;
                nxt_host.sync_left = SYNC_LOAD;
            end else if (host_ff.sync_left != '0) begin
                send_sync          = 1'b1;
                nxt_host.sync_left = host_ff.sync_left - 1'b1;
            end
            // [RULE5] patterns replace data
            if (send_sync) begin
                frame_word = `SLLC_SYNC_WORD;
            end else if (fifo_out_valid) begin
                frame_word     = fifo_out_data;
                fifo_out_ready = 1'b1;
            end
            nxt_host.tx_in_sync = send_sync;
            // [RULE14] start and stop clock bits around the data
            nxt_host.tx_shreg = {`SLLC_CLK_BIT_START, sllc_bitrev(frame_word),
                                 `SLLC_CLK_BIT_STOP};
        end

        // Lock level and word toggle come from the link domain
        nxt_host.lock_meta = link_ff.locked;
        nxt_host.lock_sync = host_ff.lock_meta;
        nxt_host.tog_meta  = link_ff.word_tog;
        nxt_host.tog_sync  = host_ff.tog_meta;
        nxt_host.tog_seen  = host_ff.tog_sync;
        word_arrived       = host_ff.tog_sync ^ host_ff.tog_seen;

        // [RULE8] present each word recovered while locked
        nxt_host.rx_clk = 1'b0;
        if (word_arrived) begin
            nxt_host.rx_word = link_ff.word;
            nxt_host.rx_clk  = 1'b1;
        end

        // [RULE2] indicator low only while locked
        nxt_host.lock_n = !host_ff.lock_sync;

        // [RULE4] undriven until locked
        // [RULE13] gate pin low releases data and strobe
        nxt_host.rx_word_oe = host_ff.lock_sync && host_ff.oe_sync;
        nxt_host.rx_clk_oe  = host_ff.lock_sync && host_ff.oe_sync;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_ff <= '{
                preq_meta:  2'h0,
                preq_sync:  2'h0,
                oe_meta:    1'b0,
                oe_sync:    1'b0,
                tx_shreg:   '0,
                tx_bit_idx: LAST_BIT,
                sync_left:  '0,
                tx_in_sync: 1'b0,
                lock_meta:  1'b0,
                lock_sync:  1'b0,
                tog_meta:   1'b0,
                tog_sync:   1'b0,
                tog_seen:   1'b0,
                rx_word:    '0,
                rx_word_oe: 1'b0,
                rx_clk:     1'b0,
                rx_clk_oe:  1'b0,
                lock_n:     1'b1
            };
        end else begin
            host_ff <= nxt_host;
        end
    end

    // ------------------------------------------------------------------
    // Link clock domain: frame alignment and lock supervision
    // ------------------------------------------------------------------
    logic [`SLLC_FRAME_BITS-1:0] win;
    logic                        at_boundary;
    logic                        clk_bits_ok;
    logic                        emit;

    always_comb begin
        nxt_link = link_ff;
        emit     = 1'b0;

        nxt_link.rx_meta = rx_serial;
        nxt_link.rx_sync = link_ff.rx_meta;

        // Oldest bit in the top position
        win            = {link_ff.shreg[`SLLC_FRAME_BITS-2:0], link_ff.rx_sync};
        nxt_link.shreg = win;

        at_boundary    = link_ff.phase == LAST_BIT;
        nxt_link.phase = at_boundary ? '0 : link_ff.phase + 1'b1;

        // [RULE14] start bit one, stop bit zero
        clk_bits_ok = (win[`SLLC_FRAME_BITS-1] == `SLLC_CLK_BIT_START) &&
                      (win[0] == `SLLC_CLK_BIT_STOP);

        if (at_boundary) begin
            case (link_ff.mode)
                SLLC_RX_HUNT: begin
                    // [RULE7] slide one bit and retry on a bad frame
                    if (clk_bits_ok) begin
                        if (link_ff.good_cnt == GOOD_LAST) begin
                            nxt_link.mode    = SLLC_RX_LOCKED;
                            nxt_link.locked  = 1'b1;
                            nxt_link.bad_cnt = '0;
                            emit             = 1'b1;
                        end else begin
                            nxt_link.good_cnt = link_ff.good_cnt + 1'b1;
                        end
                    end else begin
                        nxt_link.good_cnt = '0;
                        nxt_link.phase    = LAST_BIT;
                    end
                end
                SLLC_RX_LOCKED: begin
                    emit = 1'b1;
                    if (!clk_bits_ok) begin
                        nxt_link.mode    = SLLC_RX_FADING;
                        nxt_link.bad_cnt = `SLLC_BAD_CNT_W'(1);
                    end
                end
                SLLC_RX_FADING: begin
                    if (clk_bits_ok) begin
                        nxt_link.mode    = SLLC_RX_LOCKED;
                        nxt_link.bad_cnt = '0;
                        emit             = 1'b1;
                    // [RULE9] fourth bad frame in a row drops lock
                    end else if (link_ff.bad_cnt == BAD_LAST) begin
                        // [RULE11] back to hunting for either lock path
                        nxt_link.mode     = SLLC_RX_HUNT;
                        nxt_link.locked   = 1'b0;
                        nxt_link.good_cnt = '0;
                        nxt_link.bad_cnt  = '0;
                    end else begin
                        // [RULE10] suspect words still go out
                        nxt_link.bad_cnt = link_ff.bad_cnt + 1'b1;
                        emit             = 1'b1;
                    end
                end
                default: begin
                    nxt_link.mode   = SLLC_RX_HUNT;
                    nxt_link.locked = 1'b0;
                end
            endcase
        end

        // Word stays put for a whole frame, long enough for the toggle crossing
        if (emit) begin
            nxt_link.word     = sllc_bitrev(win[`SLLC_FRAME_BITS-2:1]);
            nxt_link.word_tog = !link_ff.word_tog;
        end
    end

    always_ff @(posedge receiver_timebase or negedge rst_n) begin
        if (!rst_n) begin
            link_ff <= '{
                rx_meta:  1'b0,
                rx_sync:  1'b0,
                shreg:    '0,
                phase:    '0,
                good_cnt: '0,
                bad_cnt:  '0,
                mode:     SLLC_RX_HUNT,
                locked:   1'b0,
                word:     '0,
                word_tog: 1'b0
            };
        end else begin
            link_ff <= nxt_link;
        end
    end

endmodule

// ==== verilog/sllc_regs.svh ====
// Constants of the link lock control: frame layout, sync and lock counts.
// Assumes nothing beyond a single inclusion per compile unit.
`ifndef SLLC_REGS_SVH
`define SLLC_REGS_SVH

// Parallel word and serial frame
`define SLLC_DATA_W         10
`define SLLC_FRAME_BITS     12
`define SLLC_PHASE_W        4
`define SLLC_CLK_BIT_START  1'b1
`define SLLC_CLK_BIT_STOP   1'b0

// Pattern word: one rising edge per frame, so only one alignment fits
`define SLLC_SYNC_WORD      10'h01f
`define SLLC_IDLE_WORD      10'h000

// Least number of pattern symbols per request
`define SLLC_SYNC_MIN       1024
`define SLLC_SYNC_CNT_W     11

// Lock detector: invalid frames in a row before lock is dropped
`define SLLC_LOSS_FRAMES    4
`define SLLC_BAD_CNT_W      3
// Valid frames in a row before lock is declared
`define SLLC_LOCK_FRAMES    8
`define SLLC_GOOD_CNT_W     4

// Rates: one serial bit per system clock, well under the ceiling
`define SLLC_CLK_MHZ        100
`define SLLC_MAX_RATE_MBPS  800

// Transmit FIFO
`define SLLC_FIFO_DEPTH     32

`endif

// ==== verilog/sllc_pkg.sv ====
// Types shared by the link lock control and its transmit FIFO.
// Assumes sllc_regs.svh is on the include path.
`include "sllc_regs.svh"

package sllc_pkg;

    typedef enum logic [1:0] {
        SLLC_RX_HUNT   = 2'b00,
        SLLC_RX_LOCKED = 2'b01,
        SLLC_RX_FADING = 2'b11
    } sllc_rx_mode_t;

    // System clock domain state
    typedef struct packed {
        logic [1:0]                      preq_meta;
        logic [1:0]                      preq_sync;
        logic                            oe_meta;
        logic                            oe_sync;
        logic [`SLLC_FRAME_BITS-1:0]     tx_shreg;
        logic [`SLLC_PHASE_W-1:0]        tx_bit_idx;
        logic [`SLLC_SYNC_CNT_W-1:0]     sync_left;
        logic                            tx_in_sync;
        logic                            lock_meta;
        logic                            lock_sync;
        logic                            tog_meta;
        logic                            tog_sync;
        logic                            tog_seen;
        logic [`SLLC_DATA_W-1:0]         rx_word;
        logic                            rx_word_oe;
        logic                            rx_clk;
        logic                            rx_clk_oe;
        logic                            lock_n;
    } sllc_host_t;

    // Link clock domain state
    typedef struct packed {
        logic                            rx_meta;
        logic                            rx_sync;
        logic [`SLLC_FRAME_BITS-1:0]     shreg;
        logic [`SLLC_PHASE_W-1:0]        phase;
        logic [`SLLC_GOOD_CNT_W-1:0]     good_cnt;
        logic [`SLLC_BAD_CNT_W-1:0]      bad_cnt;
        sllc_rx_mode_t                   mode;
        logic                            locked;
        logic [`SLLC_DATA_W-1:0]         word;
        logic                            word_tog;
    } sllc_link_t;

    function automatic logic [`SLLC_DATA_W-1:0] sllc_bitrev(
        input logic [`SLLC_DATA_W-1:0] d
    );
        logic [`SLLC_DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < `SLLC_DATA_W; i++) begin
            r[i] = d[`SLLC_DATA_W-1-i];
        end
        return r;
    endfunction

endpackage

// ==== verilog/sllc_fifo.sv ====
// Single clock FIFO for parallel words waiting to be serialised.
// Assumes both sides run on clk; flags are registered.
`timescale 1ns/100ps
`include "sllc_regs.svh"

module sllc_fifo
    import sllc_pkg::*;
#(
    parameter int WIDTH = `SLLC_DATA_W,
    parameter int DEPTH = `SLLC_FIFO_DEPTH
) (
    input  wire logic             clk,       // system clock
    input  wire logic             rst_n,     // async reset, active low
    input  wire logic             in_valid,  // writer offers a word
    input  wire logic [WIDTH-1:0] in_data,   // word offered
    output logic                  in_ready,  // room for a word
    output logic                  out_valid, // a word is waiting
    output logic      [WIDTH-1:0] out_data,  // oldest word
    input  wire logic             out_ready  // reader takes the word
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
        logic          in_ready;
        logic          out_valid;
    } sllc_fifo_state_t;

    sllc_fifo_state_t st_ff;
    sllc_fifo_state_t nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign push      = in_valid && st_ff.in_ready;
    assign pop       = out_ready && st_ff.out_valid;
    assign in_ready  = st_ff.in_ready;
    assign out_valid = st_ff.out_valid;
    assign out_data  = mem[st_ff.rd_ptr];

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
        end
        nxt_st.count     = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
        nxt_st.in_ready  = nxt_st.count != (AW+1)'(DEPTH);
        nxt_st.out_valid = nxt_st.count != '0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1, out_valid: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_ff.wr_ptr] <= in_data;
        end
    end

endmodule

// ==== dv/sllc_peer.sv ====
// Peer serialiser model that drives the receive side of the link.
// Assumes one serial bit per rising edge of the link clock.
`timescale 1ns/100ps
`include "sllc_regs.svh"
module sllc_peer
    import sllc_pkg::*;
(
    input  wire logic link_clk,  // link bit clock
    input  wire logic rst_n,     // async reset, active low
    input  wire logic data_mode, // random words, else patterns
    output logic      serial     // serial frame to the receiver
);
    logic [`SLLC_FRAME_BITS-1:0] fr;
    logic [`SLLC_DATA_W-1:0]     w;
    logic [`SLLC_DATA_W-1:0]     sent[$];
    int                          bit_i;
    int                          bad_left;

    always @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial <= 1'b0;
            bit_i = 0;
        end else begin
            if (bit_i == 0) begin
                w = data_mode ? 10'($urandom) : `SLLC_SYNC_WORD;
                if (data_mode && w == `SLLC_SYNC_WORD) begin
                    w = 10'h2aa;
                end
                fr = {`SLLC_CLK_BIT_STOP, w, `SLLC_CLK_BIT_START};
                if (bad_left > 0) begin
                    fr[11] = 1'b1;
                    bad_left--;
                end
                if (data_mode) begin
                    sent.push_back(w);
                end
            end
            serial <= fr[bit_i];
            bit_i = (bit_i == 11) ? 0 : bit_i + 1;
        end
    end
endmodule

// ==== dv/sllc_top_checker.sv ====
// Port assertions for the link lock control.
// Assumes it is bound into sllc_top; system clock domain only.
`timescale 1ns/100ps
`include "sllc_regs.svh"
module sllc_top_checker
    import sllc_pkg::*;
#(
    parameter int DATA_W = `SLLC_DATA_W
) (
    input wire logic              clk,               // system clock
    input wire logic              rst_n,             // async reset
    input wire logic              pattern_request_a, // request pin
    input wire logic              pattern_request_b, // request pin
    input wire logic              tx_serial,         // serial out
    input wire logic              rx_out_enable,     // output gate
    input wire logic [DATA_W-1:0] rx_word_o,         // word out
    input wire logic              rx_word_oe,        // word enable
    input wire logic              rx_clk_o,          // word strobe
    input wire logic              rx_clk_oe,         // strobe enable
    input wire logic              link_lock_n        // lock, low
);
    logic [3:0] ph_ff;
    logic [4:0] req_ff;
    logic [3:0] nxt_ph;
    logic [4:0] nxt_req;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Frame phase and request age
    always_comb begin
        nxt_ph  = (ph_ff == 4'hb) ? 4'h0 : ph_ff + 4'h1;
        nxt_req = (req_ff == 5'h1f) ? req_ff : req_ff + 5'h01;
        if (!(pattern_request_a || pattern_request_b)) begin
            nxt_req = 5'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_ff  <= 4'h0;
            req_ff <= 5'h00;
        end else begin
            ph_ff  <= nxt_ph;
            req_ff <= nxt_req;
        end
    end

    chk_start_bit: assert property (ph_ff == 4'h1 |-> tx_serial)
        else $error("start bit missing");
    chk_stop_bit: assert property (ph_ff == 4'h0 |-> !tx_serial)
        else $error("stop bit missing");
    chk_sync_frame: assert property (ph_ff == 4'h1 && req_ff >= 5'h10
        |-> tx_serial [*6] ##1 !tx_serial [*6]) else $error("pattern frame wrong");
    chk_oe_pair: assert property (rx_clk_oe == rx_word_oe)
        else $error("enables differ");
    chk_oe_locked: assert property (rx_word_oe |-> !link_lock_n)
        else $error("driven while unlocked");
    chk_gate_off: assert property (!rx_out_enable [*3] |=> !rx_word_oe)
        else $error("gate ignored");
    chk_gate_on: assert property (!link_lock_n && $past(rx_out_enable, 3)
        |-> rx_word_oe) else $error("locked output not driven");
    chk_strobe_once: assert property (rx_clk_o |=> !rx_clk_o)
        else $error("strobe too long");
    chk_word_hold: assert property (!rx_clk_o |-> $stable(rx_word_o))
        else $error("word moved without strobe");
endmodule

bind sllc_top sllc_top_checker #(.DATA_W(DATA_W)) chk_i (
    .clk, .rst_n, .pattern_request_a, .pattern_request_b, .tx_serial,
    .rx_out_enable, .rx_word_o, .rx_word_oe, .rx_clk_o, .rx_clk_oe, .link_lock_n
);

// ==== dv/tb.sv ====
// Self-checking bench for sllc_top with a peer serialiser on the link.
// Assumes sllc_peer and the bound checker are compiled beforehand.
`timescale 1ns/100ps
`include "sllc_regs.svh"
module tb import sllc_pkg::*;;
    localparam int         SYNC_MIN = 16;
    localparam logic [9:0] SYNC     = `SLLC_SYNC_WORD;
    logic        clk, rst_n, receiver_timebase, tx_valid, tx_ready, tx_serial;
    logic        pattern_request_a, pattern_request_b, rx_serial, rx_out_enable;
    logic        rx_word_oe, rx_clk_o, rx_clk_oe, link_lock_n, req_a, data_mode;
    logic        rx_chk, rx_live, armed;
    logic [9:0]  tx_data, rx_word_o, w;
    logic [11:0] fr;
    logic [9:0]  exp_tx[$];
    int          failures, checks, cyc, bi, pat_run, last_run, n, i;

    sllc_top #(.SYNC_MIN(SYNC_MIN)) uut (
        .clk, .rst_n, .receiver_timebase, .tx_valid, .tx_data, .tx_ready,
        .pattern_request_a, .pattern_request_b, .tx_serial, .rx_serial,
        .rx_out_enable, .rx_word_o, .rx_word_oe, .rx_clk_o, .rx_clk_oe, .link_lock_n
    );
    sllc_peer peer (.link_clk(receiver_timebase), .rst_n, .data_mode, .serial(rx_serial));

    always #5 clk = ~clk;
    always #24 receiver_timebase = ~receiver_timebase;
    // lock fed back to a request
    always @(posedge clk) pattern_request_a <= link_lock_n | req_a;

    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic [9:0] rnd_word();
        logic [9:0] v;
        v = 10'($urandom);
        return (v == 10'h000 || v == SYNC) ? 10'h155 : v;
    endfunction

    task automatic wait_lock(input logic want, input int lim);
        for (int k = 0; k < lim && link_lock_n !== want; k++) @(posedge clk);
        check_bit(link_lock_n, want);
    endtask

    task automatic put_word(input logic [9:0] d);
        tx_valid <= 1'b1;
        tx_data  <= d;
        @(posedge clk);
        for (n = 0; n < 400 && tx_ready !== 1'b1; n++) @(posedge clk);
        exp_tx.push_back(d);
    endtask

    // Serial frames on tx_serial, one bit per clk
    always @(negedge clk) begin
        if (!rst_n) begin
            armed = 1'b0;
            bi = 0;
        end else if (!armed) begin
            armed = 1'b1;
        end else begin
            fr[bi] = tx_serial;
            bi++;
            if (bi == 12) begin
                bi = 0;
                check_bit(fr[0], 1'b1);
                check_bit(fr[11], 1'b0);
                w = fr[10:1];
                if (w === SYNC) begin
                    pat_run++;
                end else begin
                    last_run = (pat_run > 0) ? pat_run : last_run;
                    pat_run = 0;
                    if (w !== 10'h000) check_word(w, exp_tx.size() ? exp_tx.pop_front() : 10'h000);
                end
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (rx_chk && rx_clk_o === 1'b1) begin
            rx_live = rx_live || rx_word_o !== SYNC;
            if (rx_live) check_word(rx_word_o, peer.sent.size() ? peer.sent.pop_front() : SYNC);
        end
        if (cyc == 60000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        {clk, receiver_timebase, rst_n, tx_valid, req_a, data_mode, rx_chk} = '0;
        {pattern_request_a, pattern_request_b, tx_data} = '0;
        rx_out_enable = 1'b1;
        void'($urandom(32'hfd0b));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check_bit(link_lock_n, 1'b1);
        check_bit(rx_word_oe, 1'b0);
        wait_lock(1'b0, 3000);
        repeat (4) @(posedge clk);
        check_bit(rx_word_oe, 1'b1);
        peer.sent.delete();
        rx_live = 1'b0;
        rx_chk = 1'b1;
        data_mode <= 1'b1;
        for (i = 0; i < 8; i++) put_word(rnd_word());
        tx_valid <= 1'b0;
        for (i = 0; i < 2; i++) begin
            repeat (200) @(posedge clk);
            {pattern_request_b, req_a} <= i ? 2'b10 : 2'b01;
            repeat (14) @(posedge clk);
            {pattern_request_b, req_a} <= 2'b00;
            repeat (300) @(posedge clk);
            check_bit(last_run >= SYNC_MIN && last_run <= SYNC_MIN + 1, 1'b1);
        end
        // Stall the serialiser with patterns, then fill the buffer
        req_a <= 1'b1;
        repeat (40) @(posedge clk);
        n = 0;
        tx_data <= rnd_word();
        tx_valid <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            if (tx_ready === 1'b1) begin
                exp_tx.push_back(tx_data);
                n++;
                tx_data <= rnd_word();
            end
        end
        tx_valid <= 1'b0;
        check_word(10'(n), 10'(`SLLC_FIFO_DEPTH));
        req_a <= 1'b0;
        for (i = 0; i < 3000 && exp_tx.size() > 0; i++) @(posedge clk);
        check_word(10'(exp_tx.size()), 10'h000);
        check_bit(last_run >= SYNC_MIN, 1'b1);
        rx_chk = 1'b0;
        rx_out_enable <= 1'b0;
        repeat (4) @(posedge clk);
        check_bit(rx_word_oe, 1'b0);
        check_bit(rx_clk_oe, 1'b0);
        rx_out_enable <= 1'b1;
        repeat (4) @(posedge clk);
        check_bit(rx_word_oe, 1'b1);
        peer.bad_left = 3;
        n = 0;
        repeat (500) begin
            @(posedge clk);
            n += (link_lock_n === 1'b0) ? 0 : 1;
        end
        check_word(10'(n), 10'h000);
        peer.bad_left = 5;
        wait_lock(1'b1, 800);
        wait_lock(1'b0, 40000);
        complete_run();
    end
endmodule
